// ==== core/jdh_hub.sv ====
/*
  Debug hub with analyzer trigger logic. A user scan chain, sampled on
  ref_clk, carries commands to up to fifteen capture-core ports; an APB
  slave sets up the match units and the level sequencer.
  Assumes scan chain pins are slow levels (tck well below ref_clk / 4),
  trigger ports and port responses are on ref_clk.
*/
`timescale 1ns/1ns
// Functional notes
// - Hub serves one to fifteen capture ports
// - Each capture core owns one port
// - Hub uses exactly one of four chains
// - Build parameter picks the chain, one-four
// - Primitive inside by default, else input ports
// - Only one chain port set active
// - Spare chain of two-chain primitive brought out
// - One to sixteen trigger ports, own widths
// - Boolean or sequencer, chosen at run time; zero levels parameter leaves Boolean only
// - Cyclic sequencer, trigger after last level
// - Advance only on the level's match event
// - Per-level match unit selectable at run time
// - Run-time consecutive or loose advance mode
// - At most sixteen match units in total
module jdh_hub #(
  parameter int             NUM_PORTS  = 1,
  parameter int             CHAIN      = 1,
  parameter bit             USE_PRIM   = 1'b1,
  parameter bit             SPARE_EN   = 1'b0,
  parameter int             NUM_TRIG   = 1,
  parameter logic [15:0]    MU_EN      = 16'hffff,
  parameter logic [15:0][2:0] TRIG_WM1 = '1,
  parameter int             SEQ_LEVELS = 16
) (
  // Clock and reset
  input  wire logic                    ref_clk,
  input  wire logic                    resetn,
  // APB slave
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [7:0]              paddr,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  output logic                         irq,
  // Internal primitive: one select per user chain
  input  wire logic [3:0]              tap_sel,
  input  wire logic                    tap_tck,
  input  wire logic                    tap_tdi,
  input  wire logic                    tap_shift,
  input  wire logic                    tap_capture,
  input  wire logic                    tap_update,
  output logic      [3:0]              tap_tdo,
  // External primitive chain
  input  wire logic                    ext_sel,
  input  wire logic                    ext_tck,
  input  wire logic                    ext_tdi,
  input  wire logic                    ext_shift,
  input  wire logic                    ext_capture,
  input  wire logic                    ext_update,
  output logic                         ext_tdo,
  // Spare chain for other logic
  output logic                         spare_sel,
  output logic                         spare_shift,
  output logic                         spare_capture,
  output logic                         spare_update,
  output logic                         spare_tdi,
  input  wire logic                    spare_tdo,
  // Capture-core command ports
  output logic [jdh_pkg::MAX_PORTS-1:0]             cmd_valid,
  output logic [jdh_pkg::MAX_PORTS-1:0][15:0]       cmd_data,
  input  wire logic [jdh_pkg::MAX_PORTS-1:0][15:0]  port_resp,
  // Analyzer trigger ports
  input  wire logic [jdh_pkg::NUM_MU-1:0][7:0]      trig_in,
  output logic                         trig_out
);
  import jdh_pkg::*;

  localparam int SPARE = (CHAIN == 1) ? 2 : 1;

  typedef struct packed {
    logic [31:0]                    rdata;
    logic                           ready;
    logic                           slverr;
    logic                           irq;
    logic [31:0]                    ctrl;
    logic [15:0][3:0]               sel;
    logic [15:0]                    bool_mask;
    logic [3:0]                     mu_idx;
    logic [NUM_MU-1:0][15:0]        mu_cfg;
    logic [IRQ_W-1:0]               int_st;
    logic [IRQ_W-1:0]               int_mk;
    logic                           tck_q;
    logic [SR_W-1:0]                sr;
    logic [ADDR_W-1:0]              cur;
    logic [3:0]                     tdo;
    logic                           ext_tdo;
    logic [4:0]                     spare;
    logic [MAX_PORTS-1:0]           cvalid;
    logic [MAX_PORTS-1:0][15:0]     cdata;
    logic                           trig_q;
  } jdh_hub_t;

  jdh_hub_t           s;
  jdh_hub_t           next_s;
  logic [15:0]        raw;
  logic [15:0]        syn;
  logic               c_sel;
  logic               c_tck;
  logic               c_tdi;
  logic               c_shift;
  logic               c_cap;
  logic               c_upd;
  logic               tck_rise;
  logic [NUM_MU-1:0]  ev;
  logic               arm;
  logic               s_armed;
  logic               s_trig;
  logic [3:0]         s_level;
  logic               acc;
  logic               wr;
  logic [31:0]        rd;
  logic               hit_ok;
  logic [IRQ_W-1:0]   ev_irq;
  logic [ADDR_W-1:0]  up_addr;

  // Every scan pin is a level from the TAP domain
  // Bit 6 is a filler, so the inner group sits at [15:7] and the outer at [5:0]
  assign raw = {tap_sel, tap_tck, tap_tdi, tap_shift, tap_capture, tap_update, 1'b0,
                ext_sel, ext_tck, ext_tdi, ext_shift, ext_capture, ext_update};

  jdh_sync #(
    .W (16)
  ) u_sync (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .d       (raw),
    .q       (syn)
  );

  // Chain used by the hub: a fixed chain of the inner primitive or the input ports
  always_comb begin
    if (USE_PRIM) begin
      // A chain counts only when its select is the sole one raised
      c_sel   = syn[12+CHAIN-1] && ($countones(syn[15:12]) == 1);
      c_tck   = syn[11];
      c_tdi   = syn[10];
      c_shift = syn[9];
      c_cap   = syn[8];
      c_upd   = syn[7];
    end else begin
      c_sel   = syn[5];
      c_tck   = syn[4];
      c_tdi   = syn[3];
      c_shift = syn[2];
      c_cap   = syn[1];
      c_upd   = syn[0];
    end
  end

  assign tck_rise = c_tck && !s.tck_q;
  assign up_addr  = s.sr[ADDR_W-1:0];

  // Match units: masked compare of each port against value and care bits
  genvar gi;
  generate
    for (gi = 0; gi < NUM_MU; gi++) begin : g_mu
      logic [7:0] wmask;
      assign wmask  = 8'((9'h002 << TRIG_WM1[gi]) - 9'h001);
      // Units beyond the built trigger ports never fire
      assign ev[gi] = MU_EN[gi] && (gi < NUM_TRIG) &&
                      (((trig_in[gi] ^ s.mu_cfg[gi][7:0]) & s.mu_cfg[gi][15:8] & wmask)
                       == 8'h00);
    end
  endgenerate

  assign arm = wr && (paddr == OFS_CTRL) && pwdata[CTRL_ARM];

  jdh_seq #(
    .SEQ_LEVELS (SEQ_LEVELS)
  ) u_seq (
    .ref_clk    (ref_clk),
    .resetn     (resetn),
    .arm        (arm),
    .seq_mode   (s.ctrl[CTRL_SEQ]),
    .consec     (s.ctrl[CTRL_CONSEC]),
    .last_level (s.ctrl[CTRL_LAST+:4]),
    .level_sel  (s.sel),
    .bool_mask  (s.bool_mask),
    .ev         (ev),
    .armed      (s_armed),
    .triggered  (s_trig),
    .level      (s_level)
  );

  // One wait state: ready is raised in the second access cycle
  assign acc = psel && penable && s.ready;
  assign wr  = acc && pwrite;

  // Read mux; unmapped offsets answer with an error
  always_comb begin
    rd     = 32'h0000_0000;
    hit_ok = 1'b1;
    case (paddr)
      OFS_CTRL:   rd = {s.ctrl[31:1], 1'b0};
      OFS_STATUS: rd = {16'h0000, 4'(NUM_PORTS), 4'(CHAIN), s_level,
                        2'b00, s_trig, s_armed};
      OFS_SEL_LO: rd = s.sel[7:0];
      OFS_SEL_HI: rd = s.sel[15:8];
      OFS_BOOL:   rd = {16'h0000, s.bool_mask};
      OFS_MU_IDX: rd = {28'h0000000, s.mu_idx};
      OFS_MU_CFG: rd = {16'h0000, s.mu_cfg[s.mu_idx]};
      OFS_INT_ST: rd = {30'h0, s.int_st};
      OFS_INT_MK: rd = {30'h0, s.int_mk};
      default:    hit_ok = 1'b0;
    endcase
  end

  // Events that feed the sticky status
  always_comb begin
    ev_irq           = '0;
    ev_irq[IRQ_TRIG] = s_trig && !s.trig_q;
    ev_irq[IRQ_CMD]  = c_sel && c_upd && tck_rise && (up_addr < ADDR_W'(NUM_PORTS));
  end

  // All next-state logic of the hub
  always_comb begin
    next_s        = s;
    next_s.tck_q  = c_tck;
    next_s.trig_q = s_trig;
    next_s.cvalid = '0;
    // APB handshake
    next_s.ready  = psel && penable && !s.ready;
    next_s.slverr = psel && penable && !s.ready && !hit_ok;
    if (psel && penable && !s.ready) begin
      next_s.rdata = pwrite ? 32'h0000_0000 : rd;
    end
    if (wr) begin
      case (paddr)
        OFS_CTRL:   next_s.ctrl   = {24'h000000, pwdata[7:1], 1'b0};
        OFS_SEL_LO: next_s.sel[7:0] = pwdata;
        OFS_SEL_HI: next_s.sel[15:8] = pwdata;
        OFS_BOOL:   next_s.bool_mask = pwdata[15:0];
        OFS_MU_IDX: next_s.mu_idx = pwdata[3:0];
        OFS_MU_CFG: next_s.mu_cfg[s.mu_idx] = pwdata[15:0];
        OFS_INT_MK: next_s.int_mk = pwdata[IRQ_W-1:0];
        default:    next_s.ctrl = s.ctrl;
      endcase
    end
    // Write one to clear; a new event in the same cycle wins
    if (wr && (paddr == OFS_INT_ST)) begin
      next_s.int_st = s.int_st & ~pwdata[IRQ_W-1:0];
    end
    next_s.int_st = next_s.int_st | ev_irq;
    next_s.irq    = |(next_s.int_st & next_s.int_mk);
    // Scan chain, acting on each sampled rising tck while the hub's chain is selected
    if (c_sel && tck_rise) begin
      if (c_cap) begin
        next_s.sr = {port_resp[s.cur], s.cur};
      end else if (c_shift) begin
        next_s.sr = {c_tdi, s.sr[SR_W-1:1]};
      end else if (c_upd) begin
        // Indices past the built port count are dropped
        if (up_addr < ADDR_W'(NUM_PORTS)) begin
          next_s.cur             = up_addr;
          next_s.cvalid[up_addr] = 1'b1;
          next_s.cdata[up_addr]  = s.sr[SR_W-1:ADDR_W];
        end
      end
    end
    // Return data on the chain in use, and on the spare when it is on; the others idle low
    next_s.tdo     = 4'h0;
    next_s.ext_tdo = 1'b0;
    if (USE_PRIM) begin
      next_s.tdo[CHAIN-1] = next_s.sr[0];
    end else begin
      next_s.ext_tdo = next_s.sr[0];
    end
    // Spare chain: synchronised copies, so it suits only slow logic
    next_s.spare = 5'h00;
    if (USE_PRIM && SPARE_EN) begin
      next_s.spare = {syn[12+SPARE-1], syn[9], syn[8], syn[7], syn[10]};
      next_s.tdo[SPARE-1] = spare_tdo;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      s           <= '0;
      s.ctrl      <= CTRL_RST;
      s.bool_mask <= BOOL_RST;
      s.mu_cfg    <= {NUM_MU{MU_RST}};
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from the state register
  assign prdata        = s.rdata;
  assign pready        = s.ready;
  assign pslverr       = s.slverr;
  assign irq           = s.irq;
  assign tap_tdo       = s.tdo;
  assign ext_tdo       = s.ext_tdo;
  assign spare_sel     = s.spare[4];
  assign spare_shift   = s.spare[3];
  assign spare_capture = s.spare[2];
  assign spare_update  = s.spare[1];
  assign spare_tdi     = s.spare[0];
  assign cmd_valid     = s.cvalid;
  assign cmd_data      = s.cdata;
  assign trig_out      = s.trig_q;
endmodule

// ==== shared/jdh_pkg.sv ====
/*
  Shared constants of the debug hub and trigger sequencer: register
  offsets, field positions, reset values, scan word layout, state codes.
  Assumes a 32-bit APB slave and a 50 MHz ref_clk.
*/
package jdh_pkg;
  localparam int MAX_PORTS  = 15;  // Command ports of the hub
  localparam int NUM_CHAINS = 4;   // User scan chains behind the TAP
  localparam int NUM_MU     = 16;  // Match units, also trigger ports
  localparam int MAX_LEVELS = 16;  // Sequencer levels
  localparam int TRIG_W     = 8;   // Widest trigger port
  localparam int CMD_W      = 16;  // Command and response payload
  localparam int ADDR_W     = 4;   // Port index in the scan word
  localparam int SR_W       = CMD_W + ADDR_W;
  // APB byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_SEL_LO = 8'h08;
  localparam logic [7:0] OFS_SEL_HI = 8'h0c;
  localparam logic [7:0] OFS_BOOL   = 8'h10;
  localparam logic [7:0] OFS_MU_IDX = 8'h14;
  localparam logic [7:0] OFS_MU_CFG = 8'h18;
  localparam logic [7:0] OFS_INT_ST = 8'h1c;
  localparam logic [7:0] OFS_INT_MK = 8'h20;
  // Control fields
  localparam int CTRL_ARM    = 0;
  localparam int CTRL_SEQ    = 1;
  localparam int CTRL_CONSEC = 2;
  localparam int CTRL_LAST   = 4;
  // Interrupt bits
  localparam int IRQ_TRIG = 0;
  localparam int IRQ_CMD  = 1;
  localparam int IRQ_W    = 2;
  // Reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_00f2;
  localparam logic [15:0] BOOL_RST = 16'h0000;
  localparam logic [15:0] MU_RST   = 16'h0000;
  typedef enum logic [1:0] {
    JDH_IDLE  = 2'b00,
    JDH_ARMED = 2'b01,
    JDH_DONE  = 2'b11
  } jdh_seq_st_t;
endpackage

// ==== core/jdh_sync.sv ====
/*
  Two-stage synchroniser for a vector of independent levels.
  Assumes each bit is a slow level from outside the ref_clk domain.
*/
`timescale 1ns/1ns
module jdh_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         ref_clk,
  input  wire logic         resetn,
  // Levels
  input  wire logic [W-1:0] d,
  output wire logic [W-1:0] q
);
  import jdh_pkg::*;

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } jdh_sync_st_t;

  jdh_sync_st_t s;
  jdh_sync_st_t next_s;

  // First stage feeds only the second
  always_comb begin
    next_s        = s;
    next_s.meta   = d;
    next_s.stable = s.meta;
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign q = s.stable;
endmodule

// ==== core/jdh_seq.sv ====
/*
  Trigger condition: cyclic level sequencer or Boolean OR of match events.
  Assumes match events arrive on ref_clk, one bit per match unit.
*/
`timescale 1ns/1ns
module jdh_seq #(
  parameter int SEQ_LEVELS = jdh_pkg::MAX_LEVELS
) (
  // Clock and reset
  input  wire logic                     ref_clk,
  input  wire logic                     resetn,
  // Run-time setup
  input  wire logic                     arm,
  input  wire logic                     seq_mode,
  input  wire logic                     consec,
  input  wire logic [3:0]               last_level,
  input  wire logic [15:0][3:0]         level_sel,
  input  wire logic [jdh_pkg::NUM_MU-1:0] bool_mask,
  // Events and result
  input  wire logic [jdh_pkg::NUM_MU-1:0] ev,
  output wire logic                     armed,
  output wire logic                     triggered,
  output wire logic [3:0]               level
);
  import jdh_pkg::*;

  typedef struct packed {
    jdh_seq_st_t st;
    logic [3:0]  lvl;
  } jdh_seq_t;

  jdh_seq_t s;
  jdh_seq_t next_s;
  logic     hit;
  logic     use_seq;
  logic [3:0] top;

  // Zero levels at build time leaves only the Boolean form
  assign use_seq = (SEQ_LEVELS > 0) && seq_mode;
  assign top     = (last_level > 4'(SEQ_LEVELS - 1)) ? 4'(SEQ_LEVELS - 1) : last_level;
  assign hit     = ev[level_sel[s.lvl]];

  always_comb begin
    next_s = s;
    if (arm) begin
      next_s.st  = JDH_ARMED;
      next_s.lvl = 4'h0;
    end else begin
      case (s.st)
        JDH_IDLE: begin
          next_s.lvl = 4'h0;
        end
        JDH_ARMED: begin
          if (!use_seq) begin
            if (|(ev & bool_mask)) begin
              next_s.st = JDH_DONE;
            end
          end else if (hit) begin
            if (s.lvl >= top) begin
              next_s.st  = JDH_DONE;
              next_s.lvl = 4'h0;
            end else begin
              next_s.lvl = s.lvl + 4'h1;
            end
          end else if (consec) begin
            next_s.lvl = 4'h0;
          end
        end
        JDH_DONE: begin
          next_s.lvl = 4'h0;
        end
        default: begin
          next_s = '0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign armed     = (s.st == JDH_ARMED);
  assign triggered = (s.st == JDH_DONE);
  assign level     = s.lvl;
endmodule

// ==== tb/jdh_hub_properties.sv ====
/*
  Port checker of the debug hub.
  Assumes it is bound into every jdh_hub instance.
*/
`timescale 1ns/1ns
module jdh_hub_properties
  import jdh_pkg::*;
#(
  parameter int NUM_PORTS = 1,
  parameter int CHAIN     = 1,
  parameter bit USE_PRIM  = 1'b1,
  parameter bit SPARE_EN  = 1'b0
) (
  // Clock and bus
  input wire logic                                ref_clk,
  input wire logic                                resetn,
  input wire logic                                psel,
  input wire logic                                penable,
  input wire logic                                pwrite,
  input wire logic [7:0]                          paddr,
  input wire logic [31:0]                         pwdata,
  input wire logic                                pready,
  input wire logic                                pslverr,
  // Scan side
  input wire logic [3:0]                          tap_tdo,
  input wire logic                                ext_tdo,
  input wire logic                                spare_sel,
  input wire logic                                spare_tdi,
  // Command ports and trigger
  input wire logic [jdh_pkg::MAX_PORTS-1:0]       cmd_valid,
  input wire logic [jdh_pkg::MAX_PORTS-1:0][15:0] cmd_data,
  input wire logic                                trig_out
);
  localparam logic [3:0] CH_MASK = 4'h1 << (CHAIN - 1);
  logic       arm_w;
  logic [2:0] arm_sr;
  // Trigger may only fall a few cycles after an arm write lands
  assign arm_w = psel && penable && pready && pwrite && paddr == OFS_CTRL && pwdata[CTRL_ARM];
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      arm_sr <= 3'h0;
    end else begin
      arm_sr <= {arm_sr[1:0], arm_w};
    end
  end
  default clocking dcb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  a_ready_wait: assert property (psel && penable && !pready |=> pready)
    else $error("pready missed its wait state");
  a_ready_pulse: assert property (pready |-> psel && penable ##1 !pready)
    else $error("pready outside access or too long");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_port_range: assert property ((cmd_valid >> NUM_PORTS) == '0)
    else $error("command on an absent port");
  a_one_port: assert property ($onehot0(cmd_valid))
    else $error("command on two ports");
  a_cmd_pulse: assert property (cmd_valid != '0 |=> cmd_valid == '0)
    else $error("command strobe too long");
  a_data_hold: assert property (cmd_valid == '0 |-> $stable(cmd_data))
    else $error("command data moved without strobe");
  a_chain_only: assert property (SPARE_EN || (tap_tdo & ~CH_MASK) == 4'h0)
    else $error("unused chain driven");
  a_ext_quiet: assert property (!USE_PRIM || !ext_tdo)
    else $error("external chain driven");
  a_spare_off: assert property (SPARE_EN || !(spare_sel || spare_tdi))
    else $error("spare chain driven while off");
  a_trig_hold: assert property ($fell(trig_out) |-> arm_sr != 3'h0)
    else $error("trigger dropped without re-arm");
endmodule

bind jdh_hub jdh_hub_properties #(
  .NUM_PORTS(NUM_PORTS), .CHAIN(CHAIN), .USE_PRIM(USE_PRIM), .SPARE_EN(SPARE_EN)
) u_props (
  .ref_clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
  .tap_tdo, .ext_tdo, .spare_sel, .spare_tdi, .cmd_valid, .cmd_data, .trig_out
);

// ==== tb/jdh_tap_model.sv ====
/*
  Far side of the hub: user chain driver and capture-core answers.
  Assumes ref_clk at 50 MHz; tck runs at 160 ns only inside frames.
*/
`timescale 1ns/1ns
module jdh_tap_model #(
  parameter int CHAIN = 1
) (
  // Sampling clock
  input  wire logic              ref_clk,
  // Scan chain pins
  output logic      [3:0]        tap_sel,
  output logic                   tap_tck,
  output logic                   tap_tdi,
  output logic                   tap_shift,
  output logic                   tap_capture,
  output logic                   tap_update,
  input  wire logic [3:0]        tap_tdo,
  // Capture-core answers
  output logic      [14:0][15:0] port_resp
);
  logic tdo_q;
  // Each core answers its own code, so a wrong port shows
  always_comb begin
    for (int i = 0; i < 15; i++) begin
      port_resp[i] = 16'ha000 + 16'(i);
    end
  end
  // Retimed off the falling edge so the driver reads it free of races
  always @(negedge ref_clk) tdo_q <= tap_tdo[CHAIN-1];
  // Chain idle, clock still
  initial begin
    tap_sel     = 4'h0;
    tap_tck     = 1'b0;
    tap_tdi     = 1'b0;
    tap_shift   = 1'b0;
    tap_capture = 1'b0;
    tap_update  = 1'b0;
  end
  // Half a tck period
  task half();
    repeat (4) @(posedge ref_clk);
  endtask
  task tck_pulse();
    half();
    tap_tck <= 1'b1;
    half();
    tap_tck <= 1'b0;
  endtask
  // One frame: capture, twenty bits LSB first, update; sm picks chains
  task scan(input logic [3:0] sm, input logic [19:0] w, output logic [19:0] got);
    tap_sel     <= sm;
    tap_capture <= 1'b1;
    tck_pulse();
    tap_capture <= 1'b0;
    tap_shift   <= 1'b1;
    for (int i = 0; i < 20; i++) begin
      tap_tdi <= w[i];
      half();
      got[i] = tdo_q;
      tap_tck <= 1'b1;
      half();
      tap_tck <= 1'b0;
    end
    tap_shift  <= 1'b0;
    tap_update <= 1'b1;
    tck_pulse();
    tap_update <= 1'b0;
    tap_sel    <= 4'h0;
    tap_tdi    <= ~w[19];
  endtask
endmodule

// ==== tb/tb.sv ====
/*
  Bench of the debug hub: APB setup, scan frames, sequencer runs.
  Assumes the scan model drives the chain and answers as capture cores.
*/
`timescale 1ns/1ns
module tb;
  import jdh_pkg::*;
  localparam int          NP  = 3;
  localparam int          CH  = 3;
  localparam logic [31:0] ST0 = {16'h0, 4'(NP), 4'(CH), 8'h00};
  logic                   ref_clk, resetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0]             paddr;
  logic [31:0]            pwdata, prdata, q;
  logic [3:0]             tap_sel, tap_tdo;
  logic                   tap_tck, tap_tdi, tap_shift, tap_capture, tap_update, ext_tdo;
  logic [14:0]            cmd_valid, seen_v;
  logic [14:0][15:0]      cmd_data, port_resp;
  logic [15:0][7:0]       trig_in;
  logic                   trig_out, err;
  logic [19:0]            got;
  int                     n_errors, num_checks, n_cmd;

  jdh_hub #(.NUM_PORTS(NP), .CHAIN(CH), .NUM_TRIG(16)) dut (
    .ref_clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .irq, .tap_sel, .tap_tck, .tap_tdi, .tap_shift, .tap_capture, .tap_update,
    .tap_tdo, .ext_sel(tap_sel[0]), .ext_tck(tap_tck), .ext_tdi(tap_tdi),
    .ext_shift(tap_shift), .ext_capture(tap_capture), .ext_update(tap_update), .ext_tdo,
    .spare_sel(), .spare_shift(), .spare_capture(), .spare_update(), .spare_tdi(),
    .spare_tdo(1'b0), .cmd_valid, .cmd_data, .port_resp, .trig_in, .trig_out
  );
  // Every command port has its own core behind it
  jdh_tap_model #(.CHAIN(CH)) tap (
    .ref_clk, .tap_sel, .tap_tck, .tap_tdi, .tap_shift, .tap_capture, .tap_update,
    .tap_tdo, .port_resp
  );

  always #10 ref_clk = ~ref_clk;
  // Strobes are one cycle, so they are counted as they pass
  always @(negedge ref_clk) begin
    if (cmd_valid !== 15'h0) begin
      seen_v = cmd_valid;
      n_cmd++;
    end
  end

  task test_done();
    if (n_errors == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] seen);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One APB transfer, held until pready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge ref_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    q   = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (k >= 20) begin
      n_errors++;
      test_done();
    end
  endtask
  // Settle after n edges, off the sampling edge
  task cyc(input int n);
    repeat (n) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask
  // Match unit k sees its value for exactly one cycle
  task pulse(input int k);
    trig_in[k] <= 8'h5a;
    @(posedge ref_clk);
    trig_in[k] <= 8'h00;
  endtask
  task frame(input logic [3:0] sm, input logic [19:0] w);
    @(posedge ref_clk);
    tap.scan(sm, w, got);
    cyc(8);
  endtask

  initial begin
    ref_clk = 1'b0;
    resetn  = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    trig_in = '0;
    repeat (10) @(posedge ref_clk);
    resetn <= 1'b1;
    // Reset values, read-only status, unmapped offset
    apb(0, OFS_CTRL, 0);
    chk("ctrl", CTRL_RST, q);
    apb(1, OFS_STATUS, 32'hffff);
    apb(0, OFS_STATUS, 0);
    chk("status", ST0, q);
    apb(0, 8'h40, 0);
    chk("unmapped err", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, q);
    // Commands: port 2, absent port 5, two chains selected, port 1
    frame(4'h4, {16'h1234, 4'h2});
    chk("capture", {12'h0, 16'ha000, 4'h0}, {12'h0, got});
    chk("cmd port", 32'h4, {17'h0, seen_v});
    frame(4'h4, {16'h5555, 4'h5});
    chk("response", {12'h0, 16'ha002, 4'h2}, {12'h0, got});
    frame(4'h5, {16'h7777, 4'h1});
    chk("refused", 32'h1, n_cmd);
    frame(4'h4, {16'hbeef, 4'h1});
    chk("cmd port 1", 32'h2, {17'h0, seen_v});
    chk("data 1", 32'hbeef, {16'h0, cmd_data[1]});
    chk("data 2", 32'h1234, {16'h0, cmd_data[2]});
    apb(0, OFS_INT_ST, 0);
    chk("int cmd", 32'h2, q);
    chk("irq masked", 32'h0, {31'h0, irq});
    apb(1, OFS_INT_ST, 32'h2);
    apb(0, OFS_INT_ST, 0);
    chk("int clear", 32'h0, q);
    // Units 1-3 match 5a; levels 0-2 wait on units 1-3
    for (int k = 1; k < 4; k++) begin
      apb(1, OFS_MU_IDX, 32'(k));
      apb(1, OFS_MU_CFG, 32'hff5a);
    end
    apb(1, OFS_SEL_LO, 32'h321);
    apb(1, OFS_INT_MK, 32'h1);
    apb(1, OFS_CTRL, 32'h23);
    pulse(2);
    pulse(1);
    repeat (3) @(posedge ref_clk);
    pulse(2);
    cyc(3);
    chk("early trig", 32'h0, {31'h0, trig_out});
    apb(0, OFS_STATUS, 0);
    chk("level", 32'h2, {28'h0, q[7:4]});
    pulse(3);
    cyc(3);
    chk("trig loose", 32'h1, {31'h0, trig_out});
    chk("irq", 32'h1, {31'h0, irq});
    apb(1, OFS_INT_MK, 32'h0);
    cyc(2);
    chk("irq mask", 32'h0, {31'h0, irq});
    apb(1, OFS_INT_MK, 32'h1);
    cyc(2);
    chk("irq unmask", 32'h1, {31'h0, irq});
    apb(1, OFS_INT_ST, 32'h1);
    cyc(2);
    chk("irq clear", 32'h0, {31'h0, irq});
    // Re-arm in consecutive mode; a gap falls back to level 0
    apb(1, OFS_CTRL, 32'h27);
    cyc(3);
    chk("rearm trig", 32'h0, {31'h0, trig_out});
    apb(0, OFS_STATUS, 0);
    chk("rearm level", 32'h0, {28'h0, q[7:4]});
    pulse(1);
    @(posedge ref_clk);
    pulse(2);
    pulse(3);
    cyc(3);
    chk("gap trig", 32'h0, {31'h0, trig_out});
    apb(0, OFS_STATUS, 0);
    chk("gap level", 32'h0, {28'h0, q[7:4]});
    pulse(1);
    pulse(2);
    pulse(3);
    cyc(3);
    chk("trig consec", 32'h1, {31'h0, trig_out});
    // Boolean mode: only unit 3 counts
    apb(1, OFS_BOOL, 32'h8);
    apb(1, OFS_CTRL, 32'h21);
    pulse(2);
    cyc(3);
    chk("bool off", 32'h0, {31'h0, trig_out});
    @(posedge ref_clk);
    pulse(3);
    cyc(3);
    chk("bool on", 32'h1, {31'h0, trig_out});
    test_done();
  end
endmodule
